// ### hdl/flash_self_program_regs.vh
// Register offsets, fields, reset values and timing counts of the flash self-program controller
`ifndef FLASH_SELF_PROGRAM_REGS_VH
`define FLASH_SELF_PROGRAM_REGS_VH

// ==========================================================
// Array geometry
`define NVM_WORD_W 14
`define NVM_ADDR_W 15
`define NVM_ROW_WORDS 16
`define NVM_ROW_BITS 4
`define NVM_ERASED_WORD 14'h3FFF

// ==========================================================
// Register word indices (byte address = index * 4)
`define NVM_IDX_ADDR_LOW 3'h0
`define NVM_IDX_ADDR_HIGH 3'h1
`define NVM_IDX_DATA_LOW 3'h2
`define NVM_IDX_DATA_HIGH 3'h3
`define NVM_IDX_CONTROL 3'h4
`define NVM_IDX_KEY 3'h5

// ==========================================================
// Control register bit positions
`define NVM_BIT_FETCH_GO 0
`define NVM_BIT_PROGRAM_GO 1
`define NVM_BIT_PROGRAM_ENABLE 2
`define NVM_BIT_FAULT 3
`define NVM_BIT_ERASE_SELECT 4
`define NVM_BIT_LATCH_ONLY 5
`define NVM_BIT_CONFIG_SELECT 6

// ==========================================================
// Unlock keys and reset values
`define NVM_KEY_FIRST 8'h55
`define NVM_KEY_SECOND 8'hAA
`define NVM_ADDR_RESET 15'h0000
`define NVM_DATA_RESET 14'h0000

// ==========================================================
// Timing
`define NVM_CLK_PERIOD_NS 4
`define NVM_ERASE_TIME_NS 2000000
// 2 ms erase at 4 ns per clock
`define NVM_ERASE_CYCLES 20'h7A120
`define NVM_INSTR_CLOCKS 8'h04

`endif

// ### hdl/write_latch_word.v
// One program-word write latch of the row buffer
`timescale 1ns/1ps
`default_nettype none
`include "flash_self_program_regs.vh"

module write_latch_word #(
  parameter W = `NVM_WORD_W
) (
  // Clock and reset
  input wire clk,
  input wire rstn,
  // Control
  input wire load,
  input wire clear,
  input wire [W-1:0] din,
  // Contents
  output reg [W-1:0] q,
  output reg loaded
);

  // ==========================================================
  // Latch storage, returns to erased value after a commit
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      q <= `NVM_ERASED_WORD;
      loaded <= 1'b0;
    end
    else if (load)
    begin
      q <= din;
      loaded <= 1'b1;
    end
    else if (clear)
    begin
      q <= `NVM_ERASED_WORD;
      loaded <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// ### hdl/flash_self_program_ctrl.v
// Flash self-programming controller: read, unlock, latch load, row erase and program
//
// How it works
// R1: Flash is rows of 14-bit words; a row is the smallest erasable unit.
// R2: A row erase covers 16 words; sixteen word write latches exist.
// R3: Latches are not addressable; they fill only through the data pair.
// R4: Erased words program without erase; unloaded latches leave other words untouched.
// R5: Software loads address, clears config select, then sets the fetch bit.
// R6: Flash is read in the second instruction cycle; that instruction is discarded.
// R7: Fetched word lands in the data pair the cycle after the access.
// R8: Data pair keeps its value until another read or a software write.
// R9: Software follows a read request with two no-operation instructions.
// R10: Erase, latch load and commits need a complete unbroken unlock sequence.
// R11: Software writes 55h, then AAh to the key, then sets program go.
// R12: Setting program go always forces two no-operation instructions.
// R13: Row erase or program stalls execution until the 2 ms operation ends.
// R14: A latch load forces two no-operations and then continues without stall.
// R15: Software should mask global interrupts around the unlock sequence.
// R16: Erase takes any address inside the row, config select cleared.
// R17: Software sets erase select and program enable before unlocking an erase.
// R18: Two preparation cycles pass before execution halts for an erase.
// R19: During the stall clocks and peripherals keep running; only execution halts.
// R20: After the erase execution resumes at the third instruction after the set.
// R21: Software may only set the go bits; hardware clears them on completion.
// R22: Writes and erases need program enable, which resets cleared.
// R23: A reset that interrupts a write sets the program fault flag.
// R24: Address pair holds 15 bits; data pair holds a 14-bit word.
// R25: Program go without the two keys just before it is ignored.
//
// Implementation choices: the Avalon-MM register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "flash_self_program_regs.vh"

module flash_self_program_ctrl #(
  parameter [19:0] ERASE_CYCLES = `NVM_ERASE_CYCLES,
  parameter [7:0] INSTR_CLOCKS = `NVM_INSTR_CLOCKS
) (
  // Clock and resets
  input wire clk,
  input wire rstn,
  input wire pornRstn,
  // Avalon-MM slave
  input wire [4:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  // Processor core
  output wire instrCycle,
  output wire discardInstr,
  output wire cpuStall,
  // Flash array
  output reg [`NVM_ADDR_W-1:0] flashAddr,
  output reg flashConfigSpace,
  output reg flashRead,
  input wire [`NVM_WORD_W-1:0] flashReadData,
  output reg flashErase,
  output reg flashProgram,
  output wire [`NVM_ROW_WORDS*`NVM_WORD_W-1:0] flashRowData,
  output wire [`NVM_ROW_WORDS-1:0] flashRowMask
);

  // ==========================================================
  // Sequencer states
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_RD1 = 3'h1;
  localparam [2:0] ST_RD2 = 3'h2;
  localparam [2:0] ST_PG1 = 3'h3;
  localparam [2:0] ST_PG2 = 3'h4;
  localparam [2:0] ST_STALL = 3'h5;

  // Unlock tracker states
  localparam [1:0] KEY_NONE = 2'h0;
  localparam [1:0] KEY_ONE = 2'h1;
  localparam [1:0] KEY_TWO = 2'h2;

  // ==========================================================
  // Registers and internal signals
  reg [`NVM_ADDR_W-1:0] addrPair;
  reg [`NVM_WORD_W-1:0] dataPair;
  reg fetchGo;
  reg programGo;
  reg programEnable;
  reg eraseSelect;
  reg latchOnly;
  reg configSelect;
  reg faultFlag;
  reg writeActive;
  reg [1:0] keyState;
  reg [2:0] state;
  reg [19:0] timer;
  reg [7:0] divCnt;
  reg ack;
  reg latchLoad;
  reg latchClear;
  wire access;
  wire wrHit;
  wire [2:0] regIdx;
  wire [7:0] wByte;
  wire goAccept;
  wire stallDone;

  // ==========================================================
  // Bus handshake: every access answers one cycle after it arrives
  assign access = (avs_read | avs_write) & ~ack;
  assign avs_waitrequest = (avs_read | avs_write) & ~ack;
  assign wrHit = avs_write & ack & avs_byteenable[0];
  assign regIdx = avs_address[4:2];
  assign wByte = avs_writedata[7:0];

  // Acknowledge pulse
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      ack <= 1'b0;
    else
      ack <= access;
  end

  // Read data, captured as the answer is raised
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      avs_readdata <= 32'h00000000;
    else if (access && avs_read)
    begin
      case (regIdx)
        `NVM_IDX_ADDR_LOW: avs_readdata <= {24'h000000, addrPair[7:0]};
        `NVM_IDX_ADDR_HIGH: avs_readdata <= {25'h0000000, addrPair[14:8]}; // R24
        `NVM_IDX_DATA_LOW: avs_readdata <= {24'h000000, dataPair[7:0]};
        `NVM_IDX_DATA_HIGH: avs_readdata <= {26'h0000000, dataPair[13:8]}; // R24
        `NVM_IDX_CONTROL: avs_readdata <= {25'h0000000, configSelect, latchOnly,
          eraseSelect, faultFlag, programEnable, programGo, fetchGo};
        default: avs_readdata <= 32'h00000000; // Key reads zero, unmapped zero
      endcase
    end
  end

  // ==========================================================
  // Instruction cycle enable from the core clock
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      divCnt <= 8'h00;
    else if (divCnt == INSTR_CLOCKS - 8'h01)
      divCnt <= 8'h00;
    else
      divCnt <= divCnt + 8'h01;
  end

  assign instrCycle = (divCnt == INSTR_CLOCKS - 8'h01);

  // ==========================================================
  // Unlock tracker: the keys must be the two writes just before go
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      keyState <= KEY_NONE;
    else if (wrHit)
    begin
      if (regIdx == `NVM_IDX_KEY && wByte == `NVM_KEY_FIRST)
        keyState <= KEY_ONE; // R11
      else if (regIdx == `NVM_IDX_KEY && wByte == `NVM_KEY_SECOND && keyState == KEY_ONE)
        keyState <= KEY_TWO; // R11
      else
        keyState <= KEY_NONE; // R25
    end
  end

  // Program go is taken only right after both keys, with writes enabled
  assign goAccept = wrHit && regIdx == `NVM_IDX_CONTROL && wByte[`NVM_BIT_PROGRAM_GO]
    && !programGo && !fetchGo && !wByte[`NVM_BIT_FETCH_GO] && keyState == KEY_TWO // R10 R25
    && (programEnable || wByte[`NVM_BIT_PROGRAM_ENABLE]); // R22

  assign stallDone = (state == ST_STALL) && (timer == ERASE_CYCLES - 20'h00001);

  // ==========================================================
  // Address pair and control fields written by software
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      addrPair <= `NVM_ADDR_RESET;
      programEnable <= 1'b0; // R22
      eraseSelect <= 1'b0;
      latchOnly <= 1'b0;
      configSelect <= 1'b0;
    end
    else if (wrHit && state == ST_IDLE)
    begin
      case (regIdx)
        `NVM_IDX_ADDR_LOW: addrPair[7:0] <= wByte;
        `NVM_IDX_ADDR_HIGH: addrPair[14:8] <= wByte[6:0]; // R24
        `NVM_IDX_CONTROL:
        begin
          programEnable <= wByte[`NVM_BIT_PROGRAM_ENABLE];
          eraseSelect <= wByte[`NVM_BIT_ERASE_SELECT];
          latchOnly <= wByte[`NVM_BIT_LATCH_ONLY];
          configSelect <= wByte[`NVM_BIT_CONFIG_SELECT];
        end
        default: addrPair <= addrPair;
      endcase
    end
  end

  // ==========================================================
  // Data pair: a completed read overrides a software write
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      dataPair <= `NVM_DATA_RESET;
    else if (state == ST_RD2 && instrCycle)
      dataPair <= flashReadData; // R7
    else if (wrHit && regIdx == `NVM_IDX_DATA_LOW)
      dataPair[7:0] <= wByte; // R8
    else if (wrHit && regIdx == `NVM_IDX_DATA_HIGH)
      dataPair[13:8] <= wByte[5:0]; // R8
  end

  // ==========================================================
  // Go bits: set by software only, cleared by hardware at completion
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      fetchGo <= 1'b0;
      programGo <= 1'b0;
    end
    else
    begin
      if (wrHit && regIdx == `NVM_IDX_CONTROL && wByte[`NVM_BIT_FETCH_GO]
          && state == ST_IDLE && !programGo)
        fetchGo <= 1'b1; // R21
      else if (state == ST_RD2 && instrCycle)
        fetchGo <= 1'b0; // R21
      if (goAccept && state == ST_IDLE)
        programGo <= 1'b1; // R21
      else if ((state == ST_PG2 && instrCycle && latchOnly && !eraseSelect) || stallDone)
        programGo <= 1'b0; // R21
    end
  end

  // ==========================================================
  // Sequencer in instruction cycles
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state <= ST_IDLE;
      timer <= 20'h00000;
      flashRead <= 1'b0;
      flashErase <= 1'b0;
      flashProgram <= 1'b0;
      latchLoad <= 1'b0;
      latchClear <= 1'b0;
    end
    else
    begin
      flashErase <= 1'b0;
      flashProgram <= 1'b0;
      latchLoad <= 1'b0;
      latchClear <= 1'b0;
      case (state)
        ST_IDLE:
        begin
          if (wrHit && regIdx == `NVM_IDX_CONTROL && wByte[`NVM_BIT_FETCH_GO] && !programGo)
            state <= ST_RD1; // R5
          else if (goAccept)
            state <= ST_PG1; // R12
        end
        ST_RD1:
        begin
          if (instrCycle)
          begin
            state <= ST_RD2; // R6
            flashRead <= 1'b1; // R6
          end
        end
        ST_RD2:
        begin
          if (instrCycle)
          begin
            state <= ST_IDLE; // R7
            flashRead <= 1'b0;
          end
        end
        ST_PG1:
        begin
          if (instrCycle)
            state <= ST_PG2; // R18
        end
        ST_PG2:
        begin
          if (instrCycle)
          begin
            if (latchOnly && !eraseSelect)
            begin
              state <= ST_IDLE; // R14
              latchLoad <= 1'b1; // R3
            end
            else
            begin
              state <= ST_STALL; // R13
              timer <= 20'h00000;
              flashErase <= eraseSelect; // R16
              flashProgram <= ~eraseSelect; // R4
            end
          end
        end
        ST_STALL:
        begin
          if (stallDone)
          begin
            state <= ST_IDLE; // R20
            latchClear <= ~eraseSelect;
          end
          else
            timer <= timer + 20'h00001; // R13
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Core controls: discard the slots after go, stall only execution
  assign discardInstr = (state == ST_RD2) || (state == ST_PG1) || (state == ST_PG2); // R6 R12
  assign cpuStall = (state == ST_STALL); // R19

  // Flash address, row-aligned for erase
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      flashAddr <= `NVM_ADDR_RESET;
      flashConfigSpace <= 1'b0;
    end
    else if (state == ST_PG2 || state == ST_RD1)
    begin
      flashConfigSpace <= configSelect;
      if (eraseSelect && state == ST_PG2)
        flashAddr <= {addrPair[14:`NVM_ROW_BITS], 4'h0}; // R1 R2 R16
      else
        flashAddr <= addrPair;
    end
  end

  // ==========================================================
  // Write fault: survives the device reset, set wins over clear
  always @(posedge clk or negedge pornRstn)
  begin
    if (!pornRstn)
    begin
      writeActive <= 1'b0;
      faultFlag <= 1'b0;
    end
    else
    begin
      // Stall left before its last cycle means a reset cut the write
      writeActive <= (state == ST_STALL) && !stallDone;
      if (writeActive && state != ST_STALL)
        faultFlag <= 1'b1; // R23
      else if (wrHit && regIdx == `NVM_IDX_CONTROL)
        faultFlag <= wByte[`NVM_BIT_FAULT];
    end
  end

  // ==========================================================
  // Row of write latches
  genvar gi;
  generate
    for (gi = 0; gi < `NVM_ROW_WORDS; gi = gi + 1)
    begin : latchRow
      write_latch_word #(
        .W(`NVM_WORD_W)
      ) latchWord (
        .clk(clk),
        .rstn(rstn),
        .load(latchLoad && addrPair[`NVM_ROW_BITS-1:0] == gi), // R3
        .clear(latchClear),
        .din(dataPair),
        .q(flashRowData[gi*`NVM_WORD_W +: `NVM_WORD_W]),
        .loaded(flashRowMask[gi]) // R4
      );
    end
  endgenerate

endmodule
`default_nettype wire

// ### dv/flash_self_program_ctrl_chk.sv
// Checker for the flash self-program controller ports
`timescale 1ns/1ps
`default_nettype none

module flash_self_program_ctrl_chk #(
  parameter [19:0] ERASE_CYCLES = 20'h00014
) (
  // Clock and reset
  input wire clk,
  input wire rstn,
  // Bus
  input wire avs_read,
  input wire avs_write,
  input wire avs_waitrequest,
  // Core and array
  input wire instrCycle,
  input wire discardInstr,
  input wire cpuStall,
  input wire [14:0] flashAddr,
  input wire flashRead,
  input wire flashErase
);
  // ==========================================
  // Stall length counter
  reg [19:0] stallCnt;

  // Counts consecutive stalled clocks
  always @(posedge clk or negedge rstn)
    if (!rstn)
      stallCnt <= 20'h00000;
    else if (cpuStall)
      stallCnt <= stallCnt + 20'h00001;
    else
      stallCnt <= 20'h00000;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  // ==========================================
  // Properties
  chk_wait_one: assert property ($rose(avs_read | avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("waitrequest not low one cycle after request");
  chk_wait_idle: assert property (!(avs_read | avs_write) |-> !avs_waitrequest)
    else $error("waitrequest high without request");
  chk_read_discard: assert property (flashRead |-> discardInstr && !cpuStall)
    else $error("flash read outside discarded cycle");
  chk_instr_period: assert property (instrCycle |=> !instrCycle[*3] ##1 instrCycle)
    else $error("instruction cycle enable not every fourth clock");
  chk_read_len: assert property ($rose(flashRead) |-> flashRead[*4] ##1 !flashRead)
    else $error("flash read not one instruction cycle");
  chk_addr_stable: assert property (flashRead && $past(flashRead) |-> $stable(flashAddr))
    else $error("address moved during flash read");
  chk_stall_prep: assert property ($rose(cpuStall) |-> $past(discardInstr))
    else $error("stall without forced no-operation first");
  chk_stall_len: assert property ($fell(cpuStall) |-> stallCnt == ERASE_CYCLES)
    else $error("stall length wrong");
  chk_stall_max: assert property (cpuStall |-> stallCnt < ERASE_CYCLES)
    else $error("stall overran");
  chk_erase_pulse: assert property (flashErase |=> !flashErase)
    else $error("erase strobe longer than one cycle");

  cover property ($rose(flashRead));
  cover property ($fell(cpuStall));
  cover property ($rose(discardInstr) && !cpuStall);
endmodule

bind flash_self_program_ctrl flash_self_program_ctrl_chk #(.ERASE_CYCLES(ERASE_CYCLES)) chk (
  .clk(clk),
  .rstn(rstn),
  .avs_read(avs_read),
  .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest),
  .instrCycle(instrCycle),
  .discardInstr(discardInstr),
  .cpuStall(cpuStall),
  .flashAddr(flashAddr),
  .flashRead(flashRead),
  .flashErase(flashErase)
);
`default_nettype wire

// ### dv/flash_array_model.sv
// Behavioural model of the program flash array
`timescale 1ns/1ps
`default_nettype none

module flash_array_model (
  // Clock
  input wire logic clk,
  // Array access
  input wire logic [14:0] flashAddr,
  input wire logic flashRead,
  input wire logic flashErase,
  input wire logic flashProgram,
  input wire logic [223:0] flashRowData,
  input wire logic [15:0] flashRowMask,
  output logic [13:0] flashReadData
);
  logic [13:0] mem [0:127];
  integer i;

  // Preload a known pattern
  initial
  begin
    flashReadData = 14'h0000;
    for (i = 0; i < 128; i = i + 1)
      mem[i] = 14'(i * 14'h0123 + 14'h0055);
  end

  // Word out while read strobe high, toggling garbage otherwise
  always @(posedge clk)
    if (flashRead)
      flashReadData <= mem[flashAddr[6:0]];
    else
      flashReadData <= ~flashReadData;

  // Whole-row erase; commit only clears bits of loaded words
  always @(posedge clk)
    for (int j = 0; j < 16; j = j + 1)
      if (flashErase)
        mem[{flashAddr[6:4], j[3:0]}] <= 14'h3FFF;
      else if (flashProgram && flashRowMask[j])
        mem[{flashAddr[6:4], j[3:0]}] <= mem[{flashAddr[6:4], j[3:0]}] & flashRowData[14*j +: 14];
endmodule
`default_nettype wire

// ### dv/test_flash_self_program_ctrl.sv
// Testbench for the flash self-program controller
`timescale 1ns/1ps
`default_nettype none

module test_flash_self_program_ctrl;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic pornRstn = 1'b0;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h00000000;
  logic [31:0] avs_readdata;
  logic avs_waitrequest, instrCycle, discardInstr, cpuStall;
  logic [14:0] flashAddr;
  logic flashConfigSpace, flashRead, flashErase, flashProgram;
  logic [13:0] flashReadData;
  logic [223:0] flashRowData;
  logic [15:0] flashRowMask;
  integer err_count = 0;
  integer samples_checked = 0;
  integer stallCycles = 0;
  logic [31:0] v;

  always #2 clk = ~clk;

  // Count stalled clocks
  always @(posedge clk)
    if (cpuStall === 1'b1)
      stallCycles <= stallCycles + 1;

  flash_self_program_ctrl #(.ERASE_CYCLES(20'h00014)) dut (
    .clk(clk), .rstn(rstn), .pornRstn(pornRstn),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .instrCycle(instrCycle),
    .discardInstr(discardInstr), .cpuStall(cpuStall), .flashAddr(flashAddr),
    .flashConfigSpace(flashConfigSpace), .flashRead(flashRead),
    .flashReadData(flashReadData), .flashErase(flashErase),
    .flashProgram(flashProgram), .flashRowData(flashRowData), .flashRowMask(flashRowMask)
  );

  flash_array_model array (
    .clk(clk), .flashAddr(flashAddr), .flashRead(flashRead), .flashErase(flashErase),
    .flashProgram(flashProgram), .flashRowData(flashRowData),
    .flashRowMask(flashRowMask), .flashReadData(flashReadData)
  );

  function logic [13:0] pat(input integer i);
    pat = 14'(i * 14'h0123 + 14'h0055);
  endfunction

  task chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked = samples_checked + 1;
    if (g !== e)
    begin
      err_count = err_count + 1;
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  task wr(input logic [4:0] a, input logic [7:0] d);
    avs_address <= a;
    avs_writedata <= {24'h000000, d};
    avs_write <= 1'b1;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) @(posedge clk);
    avs_write <= 1'b0;
    @(posedge clk);
  endtask

  task rd(input logic [4:0] a, output logic [31:0] d);
    avs_address <= a;
    avs_read <= 1'b1;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) @(posedge clk);
    d = avs_readdata;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask

  task idle;
    rd(5'h10, v);
    while (v[1:0] !== 2'b00) rd(5'h10, v);
  endtask

  task unlock;
    wr(5'h14, 8'h55);
    wr(5'h14, 8'hAA);
  endtask

  task fetch(input logic [7:0] a, input logic [13:0] e);
    logic [31:0] w;
    wr(5'h00, a);
    wr(5'h04, 8'h00);
    wr(5'h10, 8'h01);
    idle;
    chk(flashConfigSpace, 1'b0);
    rd(5'h08, v);
    rd(5'h0C, w);
    chk({w[5:0], v[7:0]}, e);
  endtask

  task t_reset;
    rd(5'h10, v);
    chk(v, 32'h0);
    rd(5'h14, v);
    chk(v, 32'h0);
    rd(5'h18, v);
    chk(v, 32'h0);
    $display("t_reset done");
  endtask

  task t_read;
    fetch(8'h25, pat(8'h25));
    wr(5'h08, 8'h5A);
    rd(5'h08, v);
    chk(v, 32'h5A);
    rd(5'h0C, v);
    chk(v, 32'(pat(8'h25) >> 8));
    wr(5'h10, 8'h41);
    idle;
    chk(flashConfigSpace, 1'b1);
    $display("t_read done");
  endtask

  task t_nokey;
    unlock;
    wr(5'h00, 8'h23);
    wr(5'h10, 8'h26);
    rd(5'h10, v);
    chk(v[7:0], 8'h24);
    chk(flashRowMask, 16'h0000);
    $display("t_nokey done");
  endtask

  task t_latch;
    wr(5'h08, 8'h34);
    wr(5'h0C, 8'h12);
    stallCycles = 0;
    unlock;
    wr(5'h10, 8'h26);
    idle;
    chk(flashRowMask, 16'h0008);
    chk(flashRowData[55:42], 14'h1234);
    chk(stallCycles, 0);
    $display("t_latch done");
  endtask

  task t_erase;
    wr(5'h00, 8'h47);
    stallCycles = 0;
    unlock;
    wr(5'h10, 8'h16);
    idle;
    chk(stallCycles, 20);
    rd(5'h10, v);
    chk(v[3], 1'b0);
    fetch(8'h4F, 14'h3FFF);
    fetch(8'h40, 14'h3FFF);
    fetch(8'h3F, pat(8'h3F));
    $display("t_erase done");
  endtask

  task t_program;
    wr(5'h00, 8'h45);
    wr(5'h08, 8'hBC);
    wr(5'h0C, 8'h0A);
    unlock;
    wr(5'h10, 8'h26);
    idle;
    chk(flashRowMask, 16'h0028);
    stallCycles = 0;
    unlock;
    wr(5'h10, 8'h06);
    idle;
    chk(stallCycles, 20);
    chk(flashRowMask, 16'h0000);
    fetch(8'h45, 14'h0ABC);
    fetch(8'h43, 14'h1234);
    fetch(8'h46, 14'h3FFF);
    $display("t_program done");
  endtask

  task t_fault;
    unlock;
    wr(5'h10, 8'h16);
    while (cpuStall !== 1'b1) @(posedge clk);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rd(5'h10, v);
    chk(v[3], 1'b1);
    $display("t_fault done");
  endtask

  task results;
    $display("checked %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Watchdog
  initial
  begin
    repeat (20000) @(posedge clk);
    err_count = err_count + 1;
    results;
  end

  // Main sequence
  initial
  begin
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    pornRstn <= 1'b1;
    @(posedge clk);
    t_reset;
    t_read;
    t_nokey;
    t_latch;
    t_erase;
    t_program;
    t_fault;
    results;
  end
endmodule
`default_nettype wire
